// File: include/cpsc_pkg.sv
// Package of constants for the cell protection state controller
package cpsc_pkg;
  // Periodic comparator sample time and its cycle count at 100 MHz
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SAMPLE_PERIOD_MS = 12;
  localparam int unsigned SAMPLE_CYC_DEF  = (SAMPLE_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  // Nominal overcurrent qualification time
  localparam int unsigned OC_DELAY_US     = 350;
  localparam int unsigned OC_CYC_DEF      = (OC_DELAY_US * 1000) / CLK_PERIOD_NS;
  // Extra cycles per step of the delay setting
  localparam int unsigned OC_EXT_STEP_DEF = 843;
  // Counter widths
  localparam int unsigned TICK_W          = 21;
  localparam int unsigned OC_W            = 20;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT    = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK    = 8'h0C;
  // Reset values
  localparam logic [7:0] CTRL_RST         = 8'h00;
  localparam logic [3:0] INT_MASK_RST     = 4'h0;
  // Event bit positions
  localparam int unsigned EV_OV           = 0;
  localparam int unsigned EV_UV           = 1;
  localparam int unsigned EV_OC           = 2;
  localparam int unsigned EV_WARN         = 3;
  // Synchronised input bit positions
  localparam int unsigned IN_UV           = 0;
  localparam int unsigned IN_OV           = 1;
  localparam int unsigned IN_WARN         = 2;
  localparam int unsigned IN_RECOV        = 3;
  localparam int unsigned IN_OC           = 4;
  localparam int unsigned IN_NEAR         = 5;
  localparam int unsigned IN_CHG          = 6;
  localparam int unsigned IN_DIS          = 7;
  // Controller states
  typedef enum logic [2:0] {
    ST_NORMAL   = 3'b000,
    ST_OVERV    = 3'b001,
    ST_UNDERV   = 3'b010,
    ST_CHARGE   = 3'b011,
    ST_OVERCUR  = 3'b100,
    ST_DISABLED = 3'b101
  } cpsc_state_e;
  // Pass switch modes
  localparam logic [1:0] SW_OFF          = 2'h0;
  localparam logic [1:0] SW_ON           = 2'h1;
  localparam logic [1:0] SW_DISCH_ONLY   = 2'h2;
  localparam logic [1:0] SW_CHG_ONLY     = 2'h3;
endpackage

// File: src/cpsc_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs
`timescale 1ns/10ps
module cpsc_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;  // First stage, read only by second stage

  // Two flops in series
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // cpsc_sync

// File: src/cpsc_ctrl.sv
// Cell protection state controller with APB registers
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module cpsc_ctrl
  import cpsc_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC  = SAMPLE_CYC_DEF,
  parameter int unsigned OC_CYC      = OC_CYC_DEF,
  parameter int unsigned OC_EXT_STEP = OC_EXT_STEP_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cell_below_uv,
  input  wire logic        cell_above_ov,
  input  wire logic        cell_below_warn,
  input  wire logic        warning_recovery_level,
  input  wire logic        overcurrent_flag,
  input  wire logic        pack_near_cell_negative_terminal,
  input  wire logic        charger_detect,
  input  wire logic        pack_disable_in,
  output logic             pack_disable_pulldown_oe,
  output logic [1:0]       switch_mode,
  output logic             low_charge_warning,
  output logic             over_under_indicator_out,
  output logic             over_under_indicator_oe,
  output logic             irq
);
  logic [7:0]         in_s;                // Synchronised flags
  logic [TICK_W-1:0]  tick_cnt_q;          // Sample period counter
  logic               tick;                // Sample instant
  logic               uv_prev_q;           // Previous undervoltage sample
  logic               ov_prev_q;           // Previous overvoltage sample
  logic [OC_W-1:0]    oc_cnt_q;            // Overcurrent persistence count
  logic [OC_W-1:0]    oc_limit;            // Qualification length
  logic               oc_trip;             // Overcurrent declared now
  cpsc_state_e        state_q;             // Controller state
  cpsc_state_e        state_d;
  logic               warn_q;              // Warning flop
  logic               warn_d;
  logic [7:0]         short_delay_setting; // Delay extension steps
  logic [3:0]         int_stat_q;          // Sticky events
  logic [3:0]         int_stat_d;
  logic [3:0]         int_mask_q;          // Interrupt mask
  logic [3:0]         events;              // Event pulses
  logic               acc;                 // Access phase
  logic               wr_fire;             // Completing write
  logic               addr_ok;             // Mapped address
  logic [31:0]        rd_mux;              // Read data select
  logic [1:0]         sw_d;                // Next switch mode

  // Input synchroniser
  cpsc_sync #(.W(8)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({pack_disable_in, charger_detect, pack_near_cell_negative_terminal, overcurrent_flag,
                warning_recovery_level, cell_below_warn, cell_above_ov, cell_below_uv}),
    .sync_out (in_s)
  );

  // Sample tick every sample period
  assign tick = (tick_cnt_q == TICK_W'(SAMPLE_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // Remember last sample for two-in-a-row filtering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_prev_q <= 1'b0;
      ov_prev_q <= 1'b0;
    end else if (tick) begin
      uv_prev_q <= in_s[IN_UV];
      ov_prev_q <= in_s[IN_OV];
    end
  end

  // Qualification length grows with the setting
  assign oc_limit = OC_W'(OC_CYC) + OC_W'(short_delay_setting * OC_EXT_STEP);
  assign oc_trip  = in_s[IN_OC] && (oc_cnt_q > oc_limit);

  // Count uninterrupted overcurrent while switch conducts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cnt_q <= '0;
    end else if (!in_s[IN_OC] || state_q == ST_OVERCUR || state_q == ST_DISABLED
                 || state_q == ST_UNDERV) begin
      oc_cnt_q <= '0;
    end else if (!oc_trip) begin
      oc_cnt_q <= oc_cnt_q + 1'b1;
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_NORMAL: begin
        if (tick && in_s[IN_UV] && uv_prev_q) begin
          state_d = ST_UNDERV;
        end else if (tick && in_s[IN_OV] && ov_prev_q) begin
          state_d = ST_OVERV;
        end
      end
      ST_OVERV: begin
        if (tick && !in_s[IN_OV]) begin
          state_d = ST_NORMAL;
        end
      end
      ST_UNDERV: begin
        if (in_s[IN_CHG]) begin
          state_d = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (tick && in_s[IN_RECOV]) begin
          state_d = ST_NORMAL;
        end
      end
      ST_OVERCUR: begin
        if (in_s[IN_NEAR]) begin
          state_d = ST_NORMAL;
        end
      end
      ST_DISABLED: begin
        state_d = ST_NORMAL;
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
    // Overcurrent overrides all other paths
    if (oc_trip && state_q != ST_OVERCUR) begin
      state_d = ST_OVERCUR;
    end
    // Disable input high forces shutdown, except when the next state is overcurrent
    if (in_s[IN_DIS] && state_d != ST_OVERCUR) begin
      state_d = ST_DISABLED;
    end
  end

  // Warning level follows samples, dropped on undervoltage entry
  always_comb begin
    warn_d = warn_q;
    if (state_d == ST_UNDERV || state_d == ST_DISABLED) begin
      warn_d = 1'b0;
    end else if (tick) begin
      warn_d = in_s[IN_WARN];
    end
  end

  // Switch mode per state
  assign sw_d = (state_d == ST_NORMAL) ? SW_ON :
                (state_d == ST_OVERV)  ? SW_DISCH_ONLY :
                (state_d == ST_CHARGE) ? SW_CHG_ONLY : SW_OFF;

  // Event pulses on overvoltage, undervoltage and overcurrent entry and warning rise
  assign events[EV_OV]   = (state_d == ST_OVERV) && (state_q != ST_OVERV);
  assign events[EV_UV]   = (state_d == ST_UNDERV) && (state_q != ST_UNDERV);
  assign events[EV_OC]   = (state_d == ST_OVERCUR) && (state_q != ST_OVERCUR);
  assign events[EV_WARN] = warn_d && !warn_q;

  // Bus decode
  assign acc     = psel && penable;
  assign wr_fire = acc && pwrite && pready && addr_ok;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_INT_STAT) || (paddr == ADDR_INT_MASK);
  assign rd_mux  = (paddr == ADDR_CTRL)     ? {24'h000000, short_delay_setting} :
                   (paddr == ADDR_STATUS)   ? {20'h00000, in_s[3:0], 1'b0, warn_q, switch_mode,
                                               1'b0, state_q} :
                   (paddr == ADDR_INT_STAT) ? {28'h0000000, int_stat_q} :
                   (paddr == ADDR_INT_MASK) ? {28'h0000000, int_mask_q} : 32'h00000000;

  // Sticky status; set wins over write-one clear
  assign int_stat_d = (int_stat_q & ~((wr_fire && paddr == ADDR_INT_STAT) ? pwdata[3:0] : 4'h0))
                      | events;

  // Main state and output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q                  <= ST_NORMAL;
      warn_q                   <= 1'b0;
      switch_mode              <= SW_ON;
      low_charge_warning       <= 1'b0;
      over_under_indicator_out <= 1'b0;
      over_under_indicator_oe  <= 1'b0;
      pack_disable_pulldown_oe <= 1'b1;
      int_stat_q               <= 4'h0;
      irq                      <= 1'b0;
    end else begin
      state_q                  <= state_d;
      warn_q                   <= warn_d;
      switch_mode              <= sw_d;
      low_charge_warning       <= warn_d;
      over_under_indicator_out <= (state_d == ST_OVERV);
      over_under_indicator_oe  <= (state_d == ST_OVERV) || (state_d == ST_UNDERV);
      pack_disable_pulldown_oe <= 1'b1;
      int_stat_q               <= int_stat_d;
      irq                      <= |(int_stat_d & int_mask_q);
    end
  end

  // Bus slave: one wait cycle, then ready with data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      prdata              <= 32'h00000000;
      short_delay_setting <= CTRL_RST;
      int_mask_q          <= INT_MASK_RST;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !addr_ok;
      prdata  <= (acc && !pready && !pwrite) ? rd_mux : 32'h00000000;
      if (wr_fire && paddr == ADDR_CTRL) begin
        short_delay_setting <= pwdata[7:0];
      end
      if (wr_fire && paddr == ADDR_INT_MASK) begin
        int_mask_q <= pwdata[3:0];
      end
    end
  end

  // Checks
  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn) tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("sample ticks back to back");

  property p_uv_entry;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_NORMAL && tick && in_s[IN_UV] && uv_prev_q && !oc_trip && !in_s[IN_DIS])
      |=> (state_q == ST_UNDERV) && (switch_mode == SW_OFF);
  endproperty
  a_uv_entry: assert property (p_uv_entry) else $error("undervoltage not entered");

  property p_charge;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_UNDERV && in_s[IN_CHG] && !in_s[IN_DIS]) |=> state_q == ST_CHARGE;
  endproperty
  a_charge: assert property (p_charge) else $error("charger ignored");

  property p_ov_mode;
    @(posedge pclk) disable iff (!presetn) state_q == ST_OVERV |-> switch_mode == SW_DISCH_ONLY;
  endproperty
  a_ov_mode: assert property (p_ov_mode) else $error("overvoltage switch mode wrong");

  property p_normal_state_on;
    @(posedge pclk) disable iff (!presetn) state_q == ST_NORMAL |-> switch_mode == SW_ON;
  endproperty
  a_normal_state_on: assert property (p_normal_state_on) else $error("normal switch not on");

  property p_oc_qual;
    @(posedge pclk) disable iff (!presetn) $rose(state_q == ST_OVERCUR) |-> $past(oc_cnt_q) > $past(oc_limit);
  endproperty
  a_oc_qual: assert property (p_oc_qual) else $error("overcurrent declared early");

  sequence s_oc_held;
    (state_q == ST_OVERCUR && !in_s[IN_NEAR]) [*2];
  endsequence
  property p_oc_hold;
    @(posedge pclk) disable iff (!presetn) s_oc_held |-> switch_mode == SW_OFF ##1 state_q == ST_OVERCUR;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("overcurrent left early");

  property p_oc_clear;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_OVERCUR && in_s[IN_NEAR] && !in_s[IN_DIS]) |=> ##[0:1] state_q == ST_NORMAL;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("overcurrent not cleared");

  property p_warn_uv;
    @(posedge pclk) disable iff (!presetn) state_q == ST_UNDERV |-> !low_charge_warning;
  endproperty
  a_warn_uv: assert property (p_warn_uv) else $error("warning held in undervoltage");

  property p_ind;
    @(posedge pclk) disable iff (!presetn)
      over_under_indicator_oe == (state_q == ST_OVERV || state_q == ST_UNDERV)
      && (over_under_indicator_out == (state_q == ST_OVERV));
  endproperty
  a_ind: assert property (p_ind) else $error("indicator wrong for state");

  property p_recover;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_CHARGE && tick && in_s[IN_RECOV] && !oc_trip && !in_s[IN_DIS]) |=> state_q == ST_NORMAL;
  endproperty
  a_recover: assert property (p_recover) else $error("controlled charge not ended");
endmodule // cpsc_ctrl

// File: tb/cpsc_pack_model.sv
// Behavioural model of cell, load, charger and user around the controller
`timescale 1ns/10ps
module cpsc_pack_model (
  input  wire logic       pclk,
  input  wire logic [1:0] cell_level,
  input  wire logic       load_short,
  input  wire logic       unplugged,
  input  wire logic       charger_on,
  input  wire logic       user_disable,
  input  wire logic       pulldown_oe,
  output logic            cell_below_uv,
  output logic            cell_above_ov,
  output logic            cell_below_warn,
  output logic            recovery,
  output logic            overcurrent_flag,
  output logic            pack_near,
  output logic            charger_detect,
  output logic            pack_disable_in
);
  // Levels: 0 below undervoltage, 1 warning band, 2 normal, 3 above overvoltage
  initial begin
    {cell_below_uv, cell_above_ov, cell_below_warn, overcurrent_flag, pack_near, charger_detect} = '0;
    recovery        = 1'b1;
    pack_disable_in = 1'b0;
  end
  // Comparator and terminal levels change just after the rising edge
  always @(posedge pclk) begin
    cell_below_uv    <= (cell_level == 2'h0);
    cell_above_ov    <= (cell_level == 2'h3);
    cell_below_warn  <= (cell_level <= 2'h1);
    recovery         <= (cell_level >= 2'h2);
    overcurrent_flag <= load_short & ~unplugged;
    pack_near        <= unplugged;
    charger_detect   <= charger_on;
    // Floating pin reads as disabled when the pull-down is absent
    pack_disable_in  <= user_disable | ~pulldown_oe;
  end
endmodule // cpsc_pack_model

// File: tb/cell_protection_state_controller_tb.sv
// Self-checking testbench of the cell protection state controller
`timescale 1ns/10ps
module cell_protection_state_controller_tb;
  import cpsc_pkg::*;
  localparam int unsigned TS  = 20;    // Shortened sample period
  localparam int unsigned TOC = 10;    // Shortened overcurrent delay
  localparam int unsigned TST = 2;     // Shortened delay step
  localparam int          TMO = 20000; // Cycle ceiling of the run
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        uv, ov, wrn, rcv, oc, near, chg, dis, pd_oe, warn, ou_out, ou_oe, irq;
  logic [1:0]  switch_mode, cell_level;
  logic        load_short, unplugged, charger_on, user_disable;
  int          num_errors, check_count, cyc;

  // Device under test with shortened counts
  cpsc_ctrl #(.SAMPLE_CYC(TS), .OC_CYC(TOC), .OC_EXT_STEP(TST)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cell_below_uv(uv), .cell_above_ov(ov), .cell_below_warn(wrn), .warning_recovery_level(rcv),
    .overcurrent_flag(oc), .pack_near_cell_negative_terminal(near), .charger_detect(chg),
    .pack_disable_in(dis), .pack_disable_pulldown_oe(pd_oe), .switch_mode(switch_mode),
    .low_charge_warning(warn), .over_under_indicator_out(ou_out),
    .over_under_indicator_oe(ou_oe), .irq(irq));

  // Pack side model
  cpsc_pack_model pack (
    .pclk(pclk), .cell_level(cell_level), .load_short(load_short), .unplugged(unplugged),
    .charger_on(charger_on), .user_disable(user_disable), .pulldown_oe(pd_oe),
    .cell_below_uv(uv), .cell_above_ov(ov), .cell_below_warn(wrn), .recovery(rcv),
    .overcurrent_flag(oc), .pack_near(near), .charger_detect(chg), .pack_disable_in(dis));

  // Clock of 10 ns
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Comparison of a seen value against the expected one
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Wait whole cycles, ending in the time step of a rising edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Request held until ready is seen high at a rising edge
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycle ceiling against hangs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      num_errors++;
      print_verdict();
    end
  end

  // Main sequence; stimulus changes just after rising edges
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {load_short, unplugged, charger_on, user_disable} = '0;
    cell_level = 2'h2;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_cyc(1);
    chk("switch_rst", switch_mode, SW_ON);
    chk("ind_oe_rst", ou_oe, 1'b0);
    chk("pulldown_oe", pd_oe, 1'b1);
    chk("irq_rst", irq, 1'b0);
    chk("warn_rst", warn, 1'b0);
    chk("pready_rst", pready, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_rst", rd, CTRL_RST);
    chk("ctrl_err", err, 1'b0);
    apb(1'b0, ADDR_INT_MASK, 32'h0);
    chk("mask_rst", rd, INT_MASK_RST);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
    // One low sample alone must not trip
    cell_level <= 2'h0;
    wait_cyc(TS);
    cell_level <= 2'h2;
    wait_cyc(3 * TS);
    chk("single_low", switch_mode, SW_ON);
    cell_level <= 2'h1;
    wait_cyc(2 * TS);
    chk("warn_set", warn, 1'b1);
    // Undervoltage entry
    cell_level <= 2'h0;
    wait_cyc(3 * TS);
    chk("uv_switch", switch_mode, SW_OFF);
    chk("uv_warn", warn, 1'b0);
    chk("uv_oe", ou_oe, 1'b1);
    chk("uv_out", ou_out, 1'b0);
    chk("irq_masked", irq, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("uv_state", rd[2:0], ST_UNDERV);
    cell_level <= 2'h1;
    wait_cyc(3 * TS);
    chk("uv_hold", switch_mode, SW_OFF);
    charger_on <= 1'b1;
    wait_cyc(5);
    chk("chg_mode", switch_mode, SW_CHG_ONLY);
    wait_cyc(3 * TS);
    chk("chg_hold", switch_mode, SW_CHG_ONLY);
    cell_level <= 2'h2;
    wait_cyc(2 * TS);
    chk("chg_exit", switch_mode, SW_ON);
    chk("normal_state_oe", ou_oe, 1'b0);
    chk("warn_clr", warn, 1'b0);
    charger_on <= 1'b0;
    // Sticky events, mask and clear
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    chk("int_stat_uv", rd, 32'h0000000A);
    apb(1'b1, ADDR_INT_MASK, 32'h0000000F);
    wait_cyc(2);
    chk("irq_on", irq, 1'b1);
    apb(1'b1, ADDR_INT_STAT, 32'h0000000F);
    wait_cyc(2);
    chk("irq_off", irq, 1'b0);
    // Overvoltage entry and exit
    cell_level <= 2'h3;
    wait_cyc(3 * TS);
    chk("ov_switch", switch_mode, SW_DISCH_ONLY);
    chk("ov_oe", ou_oe, 1'b1);
    chk("ov_out", ou_out, 1'b1);
    cell_level <= 2'h2;
    wait_cyc(2 * TS);
    chk("ov_exit", switch_mode, SW_ON);
    apb(1'b1, ADDR_INT_STAT, 32'h0000000F);
    // Lengthened delay tolerates a longer surge
    apb(1'b1, ADDR_CTRL, 32'h3);
    load_short <= 1'b1;
    wait_cyc(TOC + 3 * TST - 2);
    load_short <= 1'b0;
    wait_cyc(5);
    chk("oc_ext", switch_mode, SW_ON);
    apb(1'b1, ADDR_CTRL, 32'h0);
    load_short <= 1'b1;
    wait_cyc(TOC - 2);
    load_short <= 1'b0;
    wait_cyc(5);
    chk("oc_short", switch_mode, SW_ON);
    load_short <= 1'b1;
    wait_cyc(TOC + 8);
    chk("oc_trip", switch_mode, SW_OFF);
    chk("oc_irq", irq, 1'b1);
    charger_on <= 1'b1;
    wait_cyc(3 * TS);
    chk("oc_hold", switch_mode, SW_OFF);
    unplugged <= 1'b1;
    wait_cyc(5);
    chk("oc_reset", switch_mode, SW_ON);
    {unplugged, load_short, charger_on} <= '0;
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    chk("int_stat_oc", rd, 32'h00000004);
    apb(1'b1, ADDR_INT_STAT, 32'h00000004);
    // User disable and release
    user_disable <= 1'b1;
    wait_cyc(5);
    chk("dis_switch", switch_mode, SW_OFF);
    user_disable <= 1'b0;
    wait_cyc(5);
    chk("dis_release", switch_mode, SW_ON);
    // Mid-run reset returns mask and interrupt to reset values
    presetn <= 1'b0;
    wait_cyc(2);
    presetn <= 1'b1;
    wait_cyc(1);
    chk("irq_rst2", irq, 1'b0);
    chk("switch_rst2", switch_mode, SW_ON);
    apb(1'b0, ADDR_INT_MASK, 32'h0);
    chk("mask_rst2", rd, INT_MASK_RST);
    print_verdict();
  end
endmodule // cell_protection_state_controller_tb
